// [src/fwsr_bus_cycle.sv]
// one read or write cycle on the flash pins
// assumes flash pins are synchronous to clk via the pin sampler inside
`timescale 1ns/1ps
module fwsr_bus_cycle
    import fwsr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic wr,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    output logic done,
    output logic [7:0] rdata_ff,
    output logic [ADDR_W-1:0] flash_addr_ff,
    output logic chip_sel_n_ff,
    output logic out_en_n_ff,
    output logic wr_strobe_n_ff,
    output logic [7:0] dq_out_ff,
    output logic dq_oe_ff,
    input wire logic [7:0] dq_in
);
    logic [7:0] dq_s1_ff, dq_s2_ff;
    logic [3:0] cnt_ff;
    logic active_ff, wr_ff;
    wire last = active_ff && (cnt_ff == 4'h0);
    assign done = last;
    always_ff @(posedge clk) begin
        if (rst) begin
            dq_s1_ff <= 8'h00;
            dq_s2_ff <= 8'h00;
        end else if (ce) begin
            dq_s1_ff <= dq_in;
            dq_s2_ff <= dq_s1_ff;
        end
    end
    // read data sampled at cycle end, after two sync stages settled
    always_ff @(posedge clk) begin
        if (rst) begin
            active_ff <= 1'b0;
            cnt_ff <= 4'h0;
            wr_ff <= 1'b0;
            rdata_ff <= 8'h00;
            flash_addr_ff <= '0;
            chip_sel_n_ff <= 1'b1;
            out_en_n_ff <= 1'b1;
            wr_strobe_n_ff <= 1'b1;
            dq_out_ff <= 8'h00;
            dq_oe_ff <= 1'b0;
        end else if (ce) begin
            if (start && !active_ff) begin
                active_ff <= 1'b1;
                cnt_ff <= CYCLE_CNT + 4'h2;
                wr_ff <= wr;
                flash_addr_ff <= addr;
                dq_out_ff <= wdata;
                dq_oe_ff <= wr;
                chip_sel_n_ff <= 1'b0;
                out_en_n_ff <= wr;
                wr_strobe_n_ff <= !wr;
            end else if (active_ff) begin
                cnt_ff <= cnt_ff - 4'h1;
                if (cnt_ff == 4'h2 && wr_ff) begin
                    wr_strobe_n_ff <= 1'b1;
                end
                if (last) begin
                    active_ff <= 1'b0;
                    chip_sel_n_ff <= 1'b1;
                    out_en_n_ff <= 1'b1;
                    dq_oe_ff <= 1'b0;
                    if (!wr_ff) begin
                        rdata_ff <= dq_s2_ff;
                    end
                end
            end
        end
    end
endmodule

// [src/fwsr_host.sv]
// host-side status poller for a byte-wide flash, apb slave for software
// assumes software already wrote the program/erase command sequence via OP_WRITE
// What this block does
// - host presents the programmed address on every status read
// - host reads inside a selected sector for valid erase status
// - after poll turns true, host takes byte data from next read; here the host stops and software starts OP_READ
// - host re-reads poll bit even when fail bit reads 1
// - host does two consecutive reads; no change means done, data next read; here the host stops and software starts OP_READ
// - toggling with fail bit set: recheck, still toggling means fail, reset; here the host flags fail and software sends OP_RESET
// - host restarts polling from the first double read after leaving
// - after failure the host issues the reset command; here the host only sets fail and software starts OP_RESET
// - reset command is one write of f0 at any address
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module fwsr_host
    import fwsr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [ADDR_W-1:0] flash_addr,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic wr_strobe_n,
    output logic [7:0] dq_out,
    output logic dq_oe,
    input wire logic [7:0] dq_in
);
    ////////////////////////////////////////////////////////////////////////
    fwsr_state_t state_ff, nxt_state;
    logic [1:0] op_ff;
    logic mode_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [7:0] data_ff, prev_ff, rdat_ff;
    logic busy_ff, done_ff, fail_ff, tmr_ff, have_prev_ff, fail_seen_ff;
    logic cyc_start, cyc_done;
    logic [7:0] cyc_rdata;

    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] r);
        reg_hit = (a == r);
    endfunction

    wire acc = psel && penable;
    wire wr_acc = acc && pwrite;
    wire go = wr_acc && reg_hit(paddr, REG_CTRL) && pwdata[CTRL_GO_POS] && !busy_ff;
    wire mapped = reg_hit(paddr, REG_CTRL) || reg_hit(paddr, REG_ADDR) || reg_hit(paddr, REG_DATA)
        || reg_hit(paddr, REG_STAT) || reg_hit(paddr, REG_RDAT);
    // a frozen block holds the access open, otherwise a write would be lost
    assign pready = ce;
    assign pslverr = acc && !mapped;
    wire [31:0] stat_word = {28'h0000000, tmr_ff, fail_ff, done_ff, busy_ff};
    assign prdata = reg_hit(paddr, REG_CTRL) ? {28'h0000000, mode_ff, op_ff, 1'b0} :
        reg_hit(paddr, REG_ADDR) ? {13'h0000, addr_ff} :
        reg_hit(paddr, REG_DATA) ? {24'h000000, data_ff} :
        reg_hit(paddr, REG_STAT) ? stat_word :
        reg_hit(paddr, REG_RDAT) ? {24'h000000, rdat_ff} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // poll evaluation; mode_ff=0 uses data polling, 1 uses toggle polling
    wire poll_true = cyc_rdata[DATA_POLL_BIT] == data_ff[DATA_POLL_BIT];
    wire tog_same = cyc_rdata[TOGGLE_BIT_ONE] == prev_ff[TOGGLE_BIT_ONE];
    wire fail_now = cyc_rdata[TIMING_LIMIT_FAIL_BIT];
    wire is_poll = op_ff == OP_POLL;
    // fail only after a recheck that still shows not done
    wire poll_ok = mode_ff ? (have_prev_ff && tog_same) : poll_true;
    wire poll_fail = !poll_ok && fail_seen_ff && (mode_ff ? have_prev_ff : 1'b1);
    assign cyc_start = state_ff == FWSR_CYC;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            FWSR_IDLE: if (go) nxt_state = FWSR_CYC;
            FWSR_CYC: if (cyc_done) nxt_state = FWSR_EVAL;
            FWSR_EVAL: begin
                if (!is_poll || poll_ok || poll_fail) nxt_state = FWSR_IDLE;
                else nxt_state = FWSR_CYC;
            end
            default: nxt_state = FWSR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= FWSR_IDLE;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (rst) begin
            op_ff <= OP_READ;
            mode_ff <= 1'b0;
            addr_ff <= '0;
            data_ff <= 8'h00;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            fail_ff <= 1'b0;
            tmr_ff <= 1'b0;
            prev_ff <= 8'h00;
            rdat_ff <= 8'h00;
            have_prev_ff <= 1'b0;
            fail_seen_ff <= 1'b0;
        end else if (ce) begin
            if (wr_acc && reg_hit(paddr, REG_ADDR) && !busy_ff) addr_ff <= pwdata[ADDR_W-1:0];
            if (wr_acc && reg_hit(paddr, REG_DATA) && !busy_ff) data_ff <= pwdata[7:0];
            if (go) begin
                op_ff <= pwdata[CTRL_OP_LSB +: 2];
                mode_ff <= pwdata[CTRL_MODE_POS];
                busy_ff <= 1'b1;
                done_ff <= 1'b0;
                fail_ff <= 1'b0;
                have_prev_ff <= 1'b0;
                fail_seen_ff <= 1'b0;
            end
            if (state_ff == FWSR_EVAL) begin
                // the sampled byte lands one clock after the cycle ends, so take it here
                rdat_ff <= cyc_rdata;
                prev_ff <= cyc_rdata;
                have_prev_ff <= 1'b1;
                fail_seen_ff <= fail_now;
                tmr_ff <= cyc_rdata[ERASE_TIMER_BIT];
                if (!is_poll || poll_ok || poll_fail) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                    fail_ff <= is_poll && poll_fail;
                end
            end
        end
    end

    // a reset op drives f0; other writes take the data register
    wire cyc_wr = (op_ff == OP_WRITE) || (op_ff == OP_RESET);
    wire [7:0] cyc_wdata = (op_ff == OP_RESET) ? RESET_CMD : data_ff;

    fwsr_bus_cycle u_cyc (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .start(cyc_start),
        .wr(cyc_wr),
        .addr(addr_ff),
        .wdata(cyc_wdata),
        .done(cyc_done),
        .rdata_ff(cyc_rdata),
        .flash_addr_ff(flash_addr),
        .chip_sel_n_ff(chip_sel_n),
        .out_en_n_ff(out_en_n),
        .wr_strobe_n_ff(wr_strobe_n),
        .dq_out_ff(dq_out),
        .dq_oe_ff(dq_oe),
        .dq_in(dq_in)
    );

    ////////////////////////////////////////////////////////////////////////
    a_busy_clears: assert property (@(posedge clk) disable iff (rst)
        ce && state_ff == FWSR_EVAL && !is_poll |=> !busy_ff && done_ff)
        else $error("busy not cleared after single op");
    a_fail_needs_bit: assert property (@(posedge clk) disable iff (rst)
        $rose(fail_ff) |-> $past(fail_seen_ff) && $past(is_poll))
        else $error("fail without prior fail bit");
    a_reset_data: assert property (@(posedge clk) disable iff (rst)
        dq_oe && op_ff == OP_RESET |-> dq_out == RESET_CMD)
        else $error("reset command byte wrong");
    a_poll_addr: assert property (@(posedge clk) disable iff (rst)
        !chip_sel_n && is_poll |-> flash_addr == addr_ff)
        else $error("status read at wrong address");
    a_tog_done: assert property (@(posedge clk) disable iff (rst)
        ce && state_ff == FWSR_EVAL && is_poll && mode_ff && have_prev_ff && tog_same
        |=> !busy_ff && !fail_ff)
        else $error("toggle stop not seen as done");
    a_dpoll_done: assert property (@(posedge clk) disable iff (rst)
        ce && state_ff == FWSR_EVAL && is_poll && !mode_ff && poll_true |=> done_ff && !fail_ff)
        else $error("data poll true not seen as done");
    a_restart_pair: assert property (@(posedge clk) disable iff (rst)
        ce && go |=> !have_prev_ff)
        else $error("toggle pair not restarted");
    a_no_oe_clash: assert property (@(posedge clk) disable iff (rst)
        !(dq_oe && !out_en_n))
        else $error("drive while flash outputs enabled");
    // strobe framing, the poll loop, read byte capture and fail clearing on a new op
    a_strobe_in_cycle: assert property (@(posedge clk) disable iff (rst)
        !wr_strobe_n |-> !chip_sel_n)
        else $error("write strobe outside chip select");
    a_poll_repeat: assert property (@(posedge clk) disable iff (rst)
        ce && state_ff == FWSR_EVAL && is_poll && !poll_ok && !poll_fail
        |=> state_ff == FWSR_CYC && busy_ff)
        else $error("unfinished poll did not read again");
    a_rdat_capture: assert property (@(posedge clk) disable iff (rst)
        ce && state_ff == FWSR_EVAL |=> rdat_ff == $past(cyc_rdata))
        else $error("read byte not captured");
    a_fail_clear_go: assert property (@(posedge clk) disable iff (rst)
        ce && go |=> busy_ff && !fail_ff)
        else $error("new op did not clear fail");
    c_tog_poll: cover property (@(posedge clk) disable iff (rst) ce && state_ff == FWSR_EVAL && is_poll && mode_ff && poll_ok);
    c_poll_done: cover property (@(posedge clk) disable iff (rst) $fell(busy_ff) && !fail_ff && is_poll);
    c_poll_fail: cover property (@(posedge clk) disable iff (rst) $rose(fail_ff));
    c_reset_op: cover property (@(posedge clk) disable iff (rst) go && pwdata[CTRL_OP_LSB +: 2] == OP_RESET);
endmodule

// [src/fwsr_pkg.sv]
// package for the flash write-status host controller
// assumes a byte-wide flash with status on the data lines, driven by fwsr_host
package fwsr_pkg;
    // own apb register map (byte addresses)
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_ADDR = 12'h004;
    localparam logic [11:0] REG_DATA = 12'h008;
    localparam logic [11:0] REG_STAT = 12'h00c;
    localparam logic [11:0] REG_RDAT = 12'h010;
    // ctrl fields
    localparam int CTRL_GO_POS = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_MODE_POS = 3;
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_POLL = 2'h2;
    localparam logic [1:0] OP_RESET = 2'h3;
    // status fields
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_DONE_POS = 1;
    localparam int STAT_FAIL_POS = 2;
    localparam int STAT_TMR_POS = 3;
    // flash bit positions on the byte data lines
    localparam int DATA_POLL_BIT = 7;
    localparam int TOGGLE_BIT_ONE = 6;
    localparam int TIMING_LIMIT_FAIL_BIT = 5;
    localparam int ERASE_TIMER_BIT = 3;
    localparam int TOGGLE_BIT_TWO = 2;
    localparam logic [7:0] RESET_CMD = 8'hf0;
    // bus cycle timing
    localparam int CLK_MHZ = 50;
    localparam int CYCLE_NS = 100;
    localparam int CYCLE_CLKS = (CYCLE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] CYCLE_CNT = 4'(CYCLE_CLKS);
    localparam int ADDR_W = 19;
    typedef enum {FWSR_IDLE, FWSR_CYC, FWSR_EVAL} fwsr_state_t;
endpackage

// [tb/fwsr_flash_model.sv]
// behavioural byte-wide flash: array reads, program/erase status, fail bit, reset command
// assumes one write cycle starts a program (unlock cycles left out), 8'h30 erases or resumes, 8'hb0 suspends, f0 resets
`timescale 1ns/1ps
module fwsr_flash_model
    import fwsr_pkg::*;
#(
    parameter int PROG_READS = 4,
    parameter int PROT_READS = 2
)(
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic wr_strobe_n,
    input wire logic [7:0] dq_wr,
    output logic [7:0] dq_rd,
    output wire logic dq_en
);
    logic [7:0] mem [16];
    logic [7:0] pd = 8'h00;
    logic [3:0] pa = 4'h0;
    logic [2:0] esec = 3'h0;
    int busy = 0;
    int ebusy = 0;
    logic tog1 = 1'b0, tog2 = 1'b0, fail = 1'b0, bad = 1'b0, erase = 1'b0, prot = 1'b0, susp = 1'b0;
    wire in_esec = susp && busy == 0 && flash_addr[18:16] == esec;
    ////////////////////////////////////////////////////////////////
    // slot 15 starts programmed to zero so a later program of ones must fail
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = (i == 15) ? 8'h00 : 8'hff;
    end
    assign dq_en = !chip_sel_n && !out_en_n;
    // suspended sectors read 1 on the poll bit with toggle bit one frozen
    assign dq_rd = in_esec ? {1'b1, tog1, fail, 1'b0, 1'b1, tog2, 2'b00}
                 : (busy > 0 || fail) ? (erase ? {1'b0, tog1, fail, 1'b0, 1'b1, tog2, 2'b00}
                                               : {~pd[7], tog1, fail, 5'h00})
                 : mem[flash_addr[3:0]];
    always @(posedge wr_strobe_n) begin
        if (!chip_sel_n && dq_wr == RESET_CMD) begin
            busy = 0;
            fail = 1'b0;
            susp = 1'b0;
        end else if (!chip_sel_n && dq_wr == 8'hb0) begin
            if (erase && busy > 0) begin
                ebusy = busy;
                busy = 0;
                susp = 1'b1;
            end
        end else if (!chip_sel_n && susp && busy == 0 && dq_wr == 8'h30) begin
            susp = 1'b0;
            erase = 1'b1;
            busy = ebusy;
        end else if (!chip_sel_n) begin
            erase = (dq_wr == 8'h30);
            esec = erase ? flash_addr[18:16] : esec;
            prot = (flash_addr[18:16] == 3'h7);
            bad = !erase && ((mem[flash_addr[3:0]] & dq_wr) != dq_wr);
            pd = dq_wr;
            pa = flash_addr[3:0];
            busy = prot ? PROT_READS : PROG_READS;
        end
    end
    // a read cycle ends when either strobe rises, so both framings count
    always @(negedge dq_en) begin
        if (busy > 0 || fail) begin
            tog1 = ~tog1;
            tog2 = erase ? ~tog2 : tog2;
        end else if (in_esec) begin
            tog2 = ~tog2;
        end
        if (busy == 1) begin
            fail = bad;
            for (int i = 0; i < 16; i++) mem[i] = (erase && !prot) ? 8'hff : mem[i];
            if (!erase && !prot && !bad) mem[pa] = pd;
        end
        if (busy > 0) busy = busy - 1;
    end
endmodule

// [tb/fwsr_host_tb.sv]
// self-checking bench for fwsr_host driving a behavioural flash model
// assumes apb with wait states while ce is low (pready follows ce) and the register map of fwsr_pkg
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("BAD %0t read %h exp %h", $time, got, exp); end end
module fwsr_host_tb
    import fwsr_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, chk_on = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, chip_sel_n, out_en_n, wr_strobe_n, dq_oe, fl_en;
    logic [ADDR_W-1:0] flash_addr;
    logic [7:0] dq_out, fl_dq, dq_in;
    logic [7:0] junk = 8'h5a;
    logic [65:0] exp_q [$];
    int n_mismatch = 0;
    int num_checks = 0;
    // a released bus shows a changing pattern, never the last byte
    assign dq_in = dq_oe ? dq_out : (fl_en ? fl_dq : junk);
    initial forever #10 clk = ~clk;
    always @(posedge clk) junk <= ~junk;
    // ce drops now and then, stretching both the bus access and the flash cycle
    always @(posedge clk) ce <= ($urandom % 8) != 0;
    fwsr_host i_fwsr_host (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_addr(flash_addr), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    fwsr_flash_model i_fwsr_flash_model (.flash_addr(flash_addr), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n), .dq_wr(dq_out), .dq_rd(fl_dq), .dq_en(fl_en));
    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && chk_on) begin
            logic [65:0] e;
            e = exp_q.pop_front();
            `CHK({pslverr, prdata} & e[65:33], e[32:0])
        end
    end
    task automatic final_report();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic c,
                       output logic [31:0] r);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        chk_on <= c;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            n_mismatch++;
            final_report();
        end
    endtask
    task automatic chk(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
        logic [31:0] r;
        exp_q.push_back({m, e});
        apb(1'b0, a, 32'h0, 1'b1, r);
    endtask
    // starts one operation and waits, bounded, until busy drops
    task automatic go(input logic [1:0] op, input logic m);
        logic [31:0] r;
        int n;
        apb(1'b1, REG_CTRL, {28'h0, m, op, 1'b1}, 1'b0, r);
        n = 0;
        do begin
            apb(1'b0, REG_STAT, 32'h0, 1'b0, r);
            n++;
        end while (r[STAT_BUSY_POS] !== 1'b0 && n < 200);
        if (n >= 200) begin
            n_mismatch++;
            final_report();
        end
    endtask
    // program or erase one byte, poll it, check status, then read the byte back
    task automatic run(input logic [18:0] a, input logic [7:0] d, input logic m, input logic [3:0] es,
                       input logic [7:0] erd);
        logic [31:0] r;
        apb(1'b1, REG_ADDR, {13'h0, a}, 1'b0, r);
        apb(1'b1, REG_DATA, {24'h0, d}, 1'b0, r);
        go(OP_WRITE, 1'b0);
        go(OP_POLL, m);
        chk(REG_STAT, {29'h0, es}, '1);
        if (es[STAT_FAIL_POS]) go(OP_RESET, 1'b0);
        go(OP_READ, 1'b0);
        chk(REG_RDAT, {25'h0, erd}, '1);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic [18:0] a;
        logic [7:0] d;
        void'($urandom(32'h6f47));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) chk(12'(4 * i), 33'h0, '1);
        chk(12'h014, 33'h100000000, '1);
        a = 19'($urandom);
        apb(1'b1, REG_ADDR, {13'h0, a}, 1'b0, r);
        chk(REG_ADDR, {14'h0, a}, '1);
        // bit 4 cleared keeps random bytes away from the erase and reset codes
        d = 8'($urandom) & 8'hef;
        run({3'h1, 12'($urandom), 4'h1}, d, 1'b0, {d[3], 3'b010}, d);
        d = 8'($urandom) & 8'hef;
        run({3'h2, 12'($urandom), 4'h2}, d, 1'b1, {d[3], 3'b010}, d);
        run({3'h7, 12'($urandom), 4'h3}, 8'h00, 1'b1, 4'b1010, 8'hff);
        run({3'h4, 12'($urandom), 4'hf}, 8'hff, 1'b0, 4'b0110, 8'h00);
        // erase of a protected sector shows status for a while and leaves slot 15 at zero
        run({3'h7, 12'($urandom), 4'hf}, 8'h30, 1'b1, 4'b0010, 8'h00);
        run({3'h5, 12'($urandom), 4'h5}, 8'h30, 1'b1, 4'b1010, 8'hff);
        // erase again (data still 30), suspend at once, poll both ways inside the suspended sector
        go(OP_WRITE, 1'b0);
        apb(1'b1, REG_DATA, 32'h000000b0, 1'b0, r);
        go(OP_WRITE, 1'b0);
        go(OP_POLL, 1'b1);
        chk(REG_STAT, 33'h00000000a, '1);
        go(OP_POLL, 1'b0);
        chk(REG_STAT, 33'h00000000a, '1);
        d = 8'($urandom) & 8'hef;
        run({3'h1, 12'($urandom), 4'h7}, d, 1'b0, {d[3], 3'b010}, d);
        d = 8'($urandom) & 8'hef;
        run({3'h2, 12'($urandom), 4'h8}, d, 1'b1, {d[3], 3'b010}, d);
        // resume the suspended erase and let it finish
        run({3'h5, 12'h000, 4'h5}, 8'h30, 1'b1, 4'b1010, 8'hff);
        final_report();
    end
endmodule
